// ===== verification/pbth_cpu_model.sv
`timescale 1ns/100ps
`default_nettype none
module pbth_cpu_model
  import pbth_pkg::*;
(
  input  wire logic         i_clk,         // Bus clock
  input  wire logic         i_rst_n,       // Async reset
  input  wire logic         i_ack_n,       // Device acknowledge
  input  wire logic         i_ts_n,        // Device snoop start
  input  wire logic         i_grant_n,     // Device data grant
  input  wire logic         i_data_oe,     // Device drives data
  input  wire logic         i_end,         // Tenure over
  output logic              o_ack_n,       // Acknowledge to device
  output logic              o_retry_n,     // Retry to device
  output logic              o_busy_n,      // Data bus busy
  output logic              o_beat_ack_n,  // Beat acknowledge
  output logic              o_tea_n,       // Error acknowledge
  output logic [HALF_W-1:0] o_high,        // High half lanes
  output logic [HALF_W-1:0] o_low          // Low half lanes
);
  int                mode;      // 0 plain, 1 slave retry, 2 snoop retry, 3 snoop error
  int                ack_lat;   // Start to acknowledge delay
  int                beats;     // Beats to acknowledge
  int                slow;      // Gap between beats
  int                busy_cnt;  // Cycles busy is held
  logic [DATA_W-1:0] dat;       // Inbound data
  int                wcnt;      // Acknowledge countdown
  int                rcnt;      // Retry countdown
  int                left;      // Beats still owed
  logic              gap;       // Skip one cycle
  logic              drv;       // Lanes driven
  // Responses change only at falling edges
  always @(negedge i_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      {o_ack_n, o_retry_n, o_busy_n, o_beat_ack_n, o_tea_n} = 5'h1f;
      {wcnt, rcnt, left, gap, drv} = '0;
      {o_high, o_low} = '0;
    end else begin
      {o_ack_n, o_beat_ack_n, o_tea_n} = 3'h7;
      o_busy_n = (busy_cnt == 0);
      if (busy_cnt > 0) busy_cnt--;
      if (mode == 1 && !i_ack_n) rcnt = 2;
      if (!i_ts_n) wcnt = ack_lat;
      else if (wcnt > 0) begin
        wcnt--;
        if (wcnt == 0) begin
          o_ack_n = 1'b0;
          if (mode == 2) rcnt = 2;
          else left = beats;
        end
      end
      o_retry_n = (rcnt == 0);
      if (rcnt > 0) rcnt--;
      // Beat or error acknowledge while the device drives data
      if (i_data_oe && left > 0) begin
        if (gap) gap = 1'b0;
        else if (mode == 3) begin
          o_tea_n = 1'b0;
          left = 0;
        end else begin
          o_beat_ack_n = 1'b0;
          left--;
          gap = slow[0];
        end
      end
      if (!i_grant_n) drv = 1'b1;
      if (i_end) drv = 1'b0;
      {o_high, o_low} = drv ? dat : ~{o_high, o_low};
    end
  end
endmodule : pbth_cpu_model
`default_nettype wire

// ===== verification/pbth_tenure_sva.sv
`timescale 1ns/100ps
`default_nettype none
module pbth_tenure_chk
  import pbth_pkg::*;
(
  input wire logic       I_CLOCK,                  // Bus clock
  input wire logic       I_RST_N,                  // Async reset
  input wire logic       I_ERR_ACK_EN,             // Error answers on
  input wire pbth_req_t  I_REQ,                    // Core request
  input wire logic       I_TRANSFER_START_N,       // Start in
  input wire logic       I_EXTENDED_START_N,       // Extended start in
  input wire logic       I_ADDRESS_ACKNOWLEDGE_N,  // Acknowledge in
  input wire logic       I_ADDRESS_RETRY_N,        // Retry in
  input wire logic       I_DATA_BUS_BUSY_N,        // Busy in
  input wire logic       O_ADDRESS_ACKNOWLEDGE_N,  // Acknowledge out
  input wire logic       O_ADDRESS_RETRY_N,        // Retry out
  input wire logic       O_ADDRESS_RETRY_OE,       // Retry enable
  input wire logic       O_ADDR_OE,                // Address enable
  input wire logic       O_DATA_GRANT_ZERO_N,      // Data grant
  input wire logic       O_BEAT_ACKNOWLEDGE_N,     // Beat acknowledge out
  input wire logic       O_TRANSFER_ERROR_ACK_N,   // Error acknowledge out
  input wire logic       O_RETRIED,                // Retried event
  input wire logic       O_ERROR                   // Error event
);
  // One clock domain for every property
  default clocking cb @(posedge I_CLOCK); endclocking
  default disable iff (!I_RST_N);

  a_ack_from_start: assert property (!O_ADDRESS_ACKNOWLEDGE_N |->
    $past(!I_TRANSFER_START_N && I_REQ.valid && I_EXTENDED_START_N))
    else $error("acknowledge without a taken start");
  a_ack_one_cycle: assert property (!O_ADDRESS_ACKNOWLEDGE_N |=> O_ADDRESS_ACKNOWLEDGE_N)
    else $error("acknowledge held too long");
  a_retry_with_ack: assert property (!O_ADDRESS_RETRY_N |->
    O_ADDRESS_RETRY_OE && !O_ADDRESS_ACKNOWLEDGE_N ##[1:3] O_RETRIED)
    else $error("retry out badly framed");
  a_grant_qualified: assert property (!O_DATA_GRANT_ZERO_N |->
    $past(I_DATA_BUS_BUSY_N && I_ADDRESS_RETRY_N) ##1 O_DATA_GRANT_ZERO_N)
    else $error("data grant not qualified");
  a_beat_after_grant: assert property ($fell(O_DATA_GRANT_ZERO_N) |->
    ##2 !O_BEAT_ACKNOWLEDGE_N)
    else $error("beat acknowledge late");
  a_error_no_beat: assert property (!O_TRANSFER_ERROR_ACK_N |->
    O_BEAT_ACKNOWLEDGE_N && O_ERROR)
    else $error("error acknowledge with beat acknowledge");
  a_error_enabled: assert property (!O_TRANSFER_ERROR_ACK_N |-> $past(I_ERR_ACK_EN))
    else $error("error acknowledge while disabled");
  a_addr_release: assert property (O_ADDR_OE && !I_ADDRESS_ACKNOWLEDGE_N |=> !O_ADDR_OE)
    else $error("address not released after acknowledge");
  a_addr_hold: assert property (O_ADDR_OE && I_ADDRESS_ACKNOWLEDGE_N |=> O_ADDR_OE)
    else $error("address released early");
endmodule : pbth_tenure_chk

bind pbth_tenure pbth_tenure_chk u_chk (.*);
`default_nettype wire

// ===== verification/tb_processor_bus_tenure_handshake.sv
`timescale 1ns/100ps
`default_nettype none
module tb_processor_bus_tenure_handshake
  import pbth_pkg::*;
;
  logic              I_CLOCK, I_RST_N, I_CE, I_ERR_ACK_EN, I_RETRY_REQ;
  pbth_req_t         I_REQ;                               // Core request
  logic [DATA_W-1:0] I_WDATA, O_RDATA;                    // Core data
  logic              I_TRANSFER_START_N, I_EXTENDED_START_N, I_ADDRESS_ACKNOWLEDGE_N;
  logic              I_ADDRESS_RETRY_N, I_DATA_BUS_BUSY_N, I_BEAT_ACKNOWLEDGE_N;
  logic              I_TRANSFER_ERROR_ACK_N, O_ADDRESS_ACKNOWLEDGE_N, O_ADDRESS_RETRY_N;
  logic [HALF_W-1:0] I_HIGH_WORD_LANES, I_LOW_WORD_LANES, O_HIGH_WORD_LANES, O_LOW_WORD_LANES;
  pbth_attr_t        I_ATTR_N, O_ATTR_N;                  // Attributes, active low
  logic              O_ADDRESS_RETRY_OE, O_TRANSFER_START_N, O_ADDR_OE, O_BUS_GRANT_ZERO_N;
  logic              O_DATA_GRANT_ZERO_N, O_BEAT_ACKNOWLEDGE_N, O_TRANSFER_ERROR_ACK_N;
  logic              O_DATA_OE, O_ATTR_OE, O_BEAT, O_DONE, O_RETRIED, O_ERROR, O_COHERENT;
  logic [LANES-1:0]  O_LANE_VALID;                        // Captured lanes
  int                mismatches, cmp_count, cyc, seed, r; // Bookkeeping
  int                n[13];                               // Event counts per tenure
  int                dirs[5] = '{1, 3, 4, 5, 6};          // Slave directions
  logic [12:0]       ev;                                  // Events this cycle

  pbth_tenure dut (.*);
  pbth_cpu_model u_cpu (.i_clk(I_CLOCK), .i_rst_n(I_RST_N), .i_ack_n(O_ADDRESS_ACKNOWLEDGE_N),
    .i_ts_n(O_TRANSFER_START_N), .i_grant_n(O_DATA_GRANT_ZERO_N), .i_data_oe(O_DATA_OE),
    .i_end(O_DONE | O_RETRIED | O_ERROR), .o_ack_n(I_ADDRESS_ACKNOWLEDGE_N),
    .o_retry_n(I_ADDRESS_RETRY_N), .o_busy_n(I_DATA_BUS_BUSY_N),
    .o_beat_ack_n(I_BEAT_ACKNOWLEDGE_N), .o_tea_n(I_TRANSFER_ERROR_ACK_N),
    .o_high(I_HIGH_WORD_LANES), .o_low(I_LOW_WORD_LANES));

  // Clock of 4 ns
  initial I_CLOCK = 1'b0;
  always #2 I_CLOCK = ~I_CLOCK;

  // Event counting and hang guard, sampled away from the launching edge
  always @(negedge I_CLOCK) begin
    ev = {!O_ADDRESS_ACKNOWLEDGE_N, !O_ADDRESS_RETRY_N, !O_DATA_GRANT_ZERO_N,
      !O_BEAT_ACKNOWLEDGE_N, !O_TRANSFER_ERROR_ACK_N, O_BEAT, O_DONE, O_RETRIED, O_ERROR,
      O_LANE_VALID == 8'hff, !O_TRANSFER_START_N,
      !O_BEAT_ACKNOWLEDGE_N && O_DATA_OE && {O_HIGH_WORD_LANES, O_LOW_WORD_LANES} === I_WDATA,
      O_ATTR_OE && O_ATTR_N === ~I_REQ.attr};
    for (int i = 0; i < 13; i++) if (ev[12-i] === 1'b1) n[i]++;
    cyc++;
    if (cyc == 10000) begin
      mismatches++;
      report_and_stop();
    end
  end

  // Compare one value
  task automatic chk(input logic [63:0] got, input logic [63:0] exp);
    cmp_count++;
    if (got !== exp) begin
      mismatches++;
      $display("ERROR t=%0t got %0h expected %0h", $time, got, exp);
    end
  endtask : chk

  // Compare event counts, negative means unchecked
  task automatic expect_counts(input int e[13]);
    for (int i = 0; i < 13; i++)
      if (e[i] >= 0) chk(64'(n[i]), 64'(e[i]));
  endtask : expect_counts

  // Wait for the tenure to close, bounded
  task automatic wait_end();
    for (int k = 0; k < 60 && n[6] + n[7] + n[8] == 0; k++) @(negedge I_CLOCK);
    repeat (4) @(negedge I_CLOCK);
  endtask : wait_end

  // Outputs while reset is held
  task automatic reset_check();
    chk({O_ADDRESS_ACKNOWLEDGE_N, O_ADDRESS_RETRY_N, O_TRANSFER_START_N}, 64'h7);
    chk({O_BEAT_ACKNOWLEDGE_N, O_TRANSFER_ERROR_ACK_N, O_DATA_GRANT_ZERO_N}, 64'h7);
    chk({O_BUS_GRANT_ZERO_N, O_ATTR_N}, 64'hf);
    chk({O_ADDRESS_RETRY_OE, O_ADDR_OE, O_DATA_OE, O_ATTR_OE}, 64'h0);
  endtask : reset_check

  // Processor-started tenure with the device as slave
  task automatic slave(input int d, input bit bu, bad, own, xr);
    int b;
    bit rt, ok, en;
    b = bu ? 4 : 1;
    @(negedge I_CLOCK);
    n = '{default: 0};
    en = 1'($random(seed));
    rt = own | xr;
    ok = !rt && !(bad && en);
    I_ERR_ACK_EN = en;
    I_RETRY_REQ = own;
    I_ATTR_N = 3'($random(seed));
    I_WDATA = {$random(seed), $random(seed)};
    u_cpu.dat = {$random(seed), $random(seed)};
    u_cpu.mode = xr;
    u_cpu.busy_cnt = $random(seed) & 3;
    I_REQ = '{1'b1, pbth_dir_t'(d), bu, bad, pbth_attr_t'(3'h0)};
    I_TRANSFER_START_N = 1'b0;
    @(negedge I_CLOCK);
    I_TRANSFER_START_N = 1'b1;
    wait_end();
    expect_counts('{1, own, ok, ok ? b : 0, bad && en && !rt, ok ? b : 0, ok, rt,
      bad && en && !rt, (ok && d > 3) ? b : 0, 0, (ok && d < 4) ? b : 0, 0});
    if (ok && d > 3) chk(O_RDATA, u_cpu.dat);
    chk(64'(O_COHERENT), 64'(!I_ATTR_N.coherent_global_attr));
    I_REQ.valid = 1'b0;
    I_RETRY_REQ = 1'b0;
    u_cpu.mode = 0;
  endtask : slave

  // Device-started snoop broadcast
  task automatic snoop(input int m, input bit bu, sl);
    @(negedge I_CLOCK);
    n = '{default: 0};
    u_cpu.mode = m;
    u_cpu.slow = sl;
    u_cpu.beats = bu ? 4 : 1;
    u_cpu.ack_lat = 1 + ($random(seed) & 3);
    I_REQ = '{1'b1, PBTH_DIR_SNOOP_WR, bu, 1'b0, pbth_attr_t'($random(seed))};
    @(negedge I_CLOCK);
    I_REQ.valid = 1'b0;
    wait_end();
    expect_counts('{0, 0, -1, 0, 0, m == 0 ? u_cpu.beats : 0, m == 0, m == 2, m == 3,
      -1, 1, -1, 1});
    u_cpu.mode = 0;
  endtask : snoop

  // Extended start from the processor
  task automatic ext(input bit en);
    @(negedge I_CLOCK);
    n = '{default: 0};
    I_ERR_ACK_EN = en;
    I_EXTENDED_START_N = 1'b0;
    @(negedge I_CLOCK);
    I_EXTENDED_START_N = 1'b1;
    wait_end();
    expect_counts('{0, 0, 0, 0, en, 0, 0, 0, en, 0, 0, 0, 0});
  endtask : ext

  // Verdict and end of run
  task automatic report_and_stop();
    $display("comparisons %0d mismatches %0d", cmp_count, mismatches);
    if (mismatches == 0 && cmp_count > 0) $display("All tests passed");
    else $display("Some tests failed");
    $finish;
  endtask : report_and_stop

  // Main sequence
  initial begin
    seed = 73912;
    {I_RST_N, I_ERR_ACK_EN, I_RETRY_REQ, I_CE} = 4'h1;
    {I_TRANSFER_START_N, I_EXTENDED_START_N} = 2'h3;
    I_REQ = '0;
    I_WDATA = '0;
    I_ATTR_N = 3'h7;
    repeat (6) @(negedge I_CLOCK);
    reset_check();
    I_RST_N = 1'b1;
    repeat (2) @(negedge I_CLOCK);
    chk(64'(O_BUS_GRANT_ZERO_N), 64'h0);
    $display("test reset done");
    foreach (dirs[i]) slave(dirs[i], 1'b1, 1'b0, 1'b0, 1'b0);
    slave(4, 1'b0, 1'b0, 1'b1, 1'b0);
    slave(5, 1'b1, 1'b0, 1'b0, 1'b1);
    repeat (40) begin
      r = $random(seed);
      slave(dirs[$unsigned(r) % 5], r[8], r[3:2] == 0, r[6:4] == 0, r[6:4] == 1);
    end
    $display("test slave done");
    for (int m = 0; m < 4; m++) if (m != 1) begin
      snoop(m, 1'b1, 1'b0);
      snoop(m, 1'b0, 1'b1);
    end
    $display("test snoop done");
    ext(1'b0);
    ext(1'b1);
    $display("test extended done");
    // Clock enable low: a start must not be taken while frozen
    @(negedge I_CLOCK);
    n = '{default: 0};
    I_CE = 1'b0;
    I_REQ = '{1'b1, PBTH_DIR_CPU_WR, 1'b0, 1'b0, pbth_attr_t'(3'h0)};
    I_TRANSFER_START_N = 1'b0;
    repeat (3) @(negedge I_CLOCK);
    I_TRANSFER_START_N = 1'b1;
    I_REQ.valid = 1'b0;
    @(negedge I_CLOCK);
    I_CE = 1'b1;
    repeat (3) @(negedge I_CLOCK);
    chk(64'(n[0] + n[2] + n[7]), 64'h0);
    $display("test freeze done");
    I_RST_N = 1'b0;
    repeat (2) @(negedge I_CLOCK);
    reset_check();
    I_RST_N = 1'b1;
    repeat (2) @(negedge I_CLOCK);
    slave(6, 1'b1, 1'b0, 1'b0, 1'b0);
    $display("test rerun done");
    report_and_stop();
  end
endmodule : tb_processor_bus_tenure_handshake
`default_nettype wire

// ===== verilog/pbth_pkg.sv
`default_nettype none
package pbth_pkg;

  // Bus shape
  localparam int LANE_W    = 8;   // Bits per byte lane
  localparam int LANES     = 8;   // Byte lanes on the data bus
  localparam int DATA_W    = 64;  // Full data bus width
  localparam int HALF_W    = 32;  // Width of each half
  localparam int BEAT_CNT_W = 2;  // Beat counter width
  localparam logic [1:0] BURST_BEATS_M1 = 2'h3; // Last beat index of a burst

  // Timing counts in cycles
  localparam logic [1:0] SLAVE_WAIT_CYC = 2'h1; // Wait cycles before each slave beat

  // Data bus direction reasons
  typedef enum logic [2:0] {
    PBTH_DIR_NONE     = 3'h0, // Bus not driven
    PBTH_DIR_PCI_RD   = 3'h1, // Return PCI read data to processor
    PBTH_DIR_SNOOP_WR = 3'h2, // Snoop-broadcast PCI write to memory
    PBTH_DIR_L2_FLUSH = 3'h3, // Flush copy-back buffer
    PBTH_DIR_CPU_WR   = 3'h4, // Receive processor write to PCI
    PBTH_DIR_PCI_MRD  = 3'h5, // Receive PCI read from memory
    PBTH_DIR_L2_LOAD  = 3'h6  // Receive copy-back buffer load
  } pbth_dir_t;

  // Access attributes, active-high inside
  typedef struct packed {
    logic cache_inhibit_attr;
    logic write_through_attr;
    logic coherent_global_attr;
  } pbth_attr_t;

  // Request from the core side
  typedef struct packed {
    logic       valid;  // Request present
    pbth_dir_t  dir;    // Reason and direction
    logic       burst;  // Four beats instead of one
    logic       bad;    // Unsupported memory transaction
    pbth_attr_t attr;   // Attributes to drive
  } pbth_req_t;

  // Tenure state machine for slave and snoop tenures, Gray in the listed order
  typedef enum logic [2:0] {
    PBTH_IDLE  = 3'b000,
    PBTH_ADDR  = 3'b001,
    PBTH_RTRY  = 3'b011,
    PBTH_DATA  = 3'b010,
    PBTH_MADDR = 3'b110,
    PBTH_MRTRY = 3'b111,
    PBTH_MDATA = 3'b101,
    PBTH_ERR   = 3'b100
  } pbth_state_t;

endpackage : pbth_pkg
`default_nettype wire

// ===== verilog/pbth_tenure.sv
`timescale 1ns/100ps
`default_nettype none
module pbth_tenure
  import pbth_pkg::*;
(
  input  wire logic              I_CLOCK,                  // Processor bus clock
  input  wire logic              I_RST_N,                  // Async system reset
  input  wire logic              I_CE,                     // Clock enable
  input  wire logic              I_ERR_ACK_EN,             // Error acknowledge enable
  input  wire logic              I_RETRY_REQ,              // Core wants this tenure retried
  input  wire pbth_req_t         I_REQ,                    // Core request
  input  wire logic [DATA_W-1:0] I_WDATA,                  // Data to drive out
  input  wire logic              I_TRANSFER_START_N,       // Processor transfer start
  input  wire logic              I_EXTENDED_START_N,       // Extended start
  input  wire logic              I_ADDRESS_ACKNOWLEDGE_N,  // Slave acknowledge in
  input  wire logic              I_ADDRESS_RETRY_N,        // Retry in
  input  wire logic              I_DATA_BUS_BUSY_N,        // Data bus busy
  input  wire logic              I_BEAT_ACKNOWLEDGE_N,     // Beat acknowledge in
  input  wire logic              I_TRANSFER_ERROR_ACK_N,   // Error acknowledge in
  input  wire logic [HALF_W-1:0] I_HIGH_WORD_LANES,        // Data high half in
  input  wire logic [HALF_W-1:0] I_LOW_WORD_LANES,         // Data low half in
  input  wire pbth_attr_t        I_ATTR_N,                 // Attributes in
  output logic                   O_ADDRESS_ACKNOWLEDGE_N,  // Acknowledge out
  output logic                   O_ADDRESS_RETRY_N,        // Retry out
  output logic                   O_ADDRESS_RETRY_OE,       // Retry drive enable
  output logic                   O_TRANSFER_START_N,       // Snoop start out
  output logic                   O_ADDR_OE,                // Address tenure drive enable
  output logic                   O_BUS_GRANT_ZERO_N,       // Address bus grant
  output logic                   O_DATA_GRANT_ZERO_N,      // Qualified data grant
  output logic                   O_BEAT_ACKNOWLEDGE_N,     // Beat acknowledge out
  output logic                   O_TRANSFER_ERROR_ACK_N,   // Error acknowledge out
  output logic [HALF_W-1:0]      O_HIGH_WORD_LANES,        // Data high half out
  output logic [HALF_W-1:0]      O_LOW_WORD_LANES,         // Data low half out
  output logic                   O_DATA_OE,                // Data bus drive enable
  output pbth_attr_t             O_ATTR_N,                 // Attributes out
  output logic                   O_ATTR_OE,                // Attribute drive enable
  output logic [DATA_W-1:0]      O_RDATA,                  // Captured data
  output logic [LANES-1:0]       O_LANE_VALID,             // Lanes captured
  output logic                   O_BEAT,                   // One beat done
  output logic                   O_DONE,                   // Tenure ended well
  output logic                   O_RETRIED,                // Tenure retried
  output logic                   O_ERROR,                  // Tenure ended in error
  output logic                   O_COHERENT                // Global access seen
);

  // Inbound and outbound reasons
  function automatic logic is_out(input pbth_dir_t d);
    is_out = (d == PBTH_DIR_PCI_RD) || (d == PBTH_DIR_SNOOP_WR) ||
             (d == PBTH_DIR_L2_FLUSH);
  endfunction : is_out

  // Lane k of the 64-bit bus, lane 0 is the top of the high half
  function automatic logic [LANE_W-1:0] lane_of(input logic [DATA_W-1:0] v,
                                                input int k);
    lane_of = v[DATA_W-1-k*LANE_W -: LANE_W];
  endfunction : lane_of

  // Registered state
  pbth_state_t            st_q, st_d;          // Tenure state
  pbth_req_t              req_q, req_d;        // Held request
  logic [BEAT_CNT_W-1:0]  beat_q, beat_d;      // Beats done
  logic [1:0]             wait_q, wait_d;      // Wait count
  logic                   address_acknowledge_q, address_acknowledge_d;      // Acknowledge out
  logic                   rtry_q, rtry_d;      // Retry out
  logic                   ts_q, ts_d;          // Snoop start out
  logic                   aoe_q, aoe_d;        // Address drive
  logic                   bg_q, bg_d;          // Bus grant
  logic                   dbg_q, dbg_d;        // Data grant
  logic                   ta_q, ta_d;          // Beat acknowledge
  logic                   tea_q, tea_d;        // Error acknowledge
  logic                   doe_q, doe_d;        // Data drive
  logic                   beat_ev_q, beat_ev_d; // Beat pulse
  logic                   done_q, done_d;      // Done pulse
  logic                   rtd_q, rtd_d;        // Retried pulse
  logic                   err_q, err_d;        // Error pulse
  logic                   coh_q, coh_d;        // Global seen
  logic [DATA_W-1:0]      rdata_q, rdata_d;    // Captured data
  logic [LANES-1:0]       lv_q, lv_d;          // Lane valid

  // Decoded active-high pins
  logic ts_in, xts_in, address_acknowledge_in, rtry_in, busy_in, ta_in, tea_in;
  logic [DATA_W-1:0] din;

  // Input polarity, active low means asserted low
  always_comb begin
    ts_in   = ~I_TRANSFER_START_N;
    xts_in  = ~I_EXTENDED_START_N;
    address_acknowledge_in = ~I_ADDRESS_ACKNOWLEDGE_N;
    rtry_in = ~I_ADDRESS_RETRY_N;
    busy_in = ~I_DATA_BUS_BUSY_N;
    ta_in   = ~I_BEAT_ACKNOWLEDGE_N;
    tea_in  = ~I_TRANSFER_ERROR_ACK_N;
    din     = {I_HIGH_WORD_LANES, I_LOW_WORD_LANES};
  end

  // Next-state logic for the tenure machine
  always_comb begin
    st_d = st_q;
    req_d = req_q;
    beat_d = beat_q;
    wait_d = wait_q;
    address_acknowledge_d = 1'b0;
    rtry_d = 1'b0;
    ts_d = 1'b0;
    aoe_d = 1'b0;
    bg_d = bg_q;
    dbg_d = 1'b0;
    ta_d = 1'b0;
    tea_d = 1'b0;
    doe_d = 1'b0;
    beat_ev_d = 1'b0;
    done_d = 1'b0;
    rtd_d = 1'b0;
    err_d = 1'b0;
    coh_d = coh_q;
    rdata_d = rdata_q;
    lv_d = 8'h00;
    unique case (st_q)
      PBTH_IDLE: begin
        bg_d = 1'b1;
        if (xts_in && I_ERR_ACK_EN) begin
          tea_d = 1'b1;
          err_d = 1'b1;
          st_d = PBTH_ERR;
        end else if (ts_in && I_REQ.valid) begin
          req_d = I_REQ;
          coh_d = ~I_ATTR_N.coherent_global_attr;
          address_acknowledge_d = 1'b1;
          rtry_d = I_RETRY_REQ;
          st_d = PBTH_ADDR;
        end else if (I_REQ.valid && I_REQ.dir == PBTH_DIR_SNOOP_WR) begin
          req_d = I_REQ;
          bg_d = 1'b0;
          ts_d = 1'b1;
          aoe_d = 1'b1;
          st_d = PBTH_MADDR;
        end
      end
      PBTH_ADDR: begin
        // Cycle of the acknowledge: retry window for the paired tenure
        if (rtry_q || rtry_in) begin
          rtd_d = 1'b1;
          st_d = PBTH_IDLE;
        end else if (req_q.bad && I_ERR_ACK_EN) begin
          tea_d = 1'b1;
          err_d = 1'b1;
          st_d = PBTH_ERR;
        end else if (!busy_in) begin
          dbg_d = 1'b1;
          beat_d = 2'h0;
          wait_d = SLAVE_WAIT_CYC;
          st_d = PBTH_DATA;
        end else begin
          st_d = PBTH_RTRY;
        end
      end
      PBTH_RTRY: begin
        // Waiting for the data bus to free up
        if (!busy_in) begin
          dbg_d = 1'b1;
          beat_d = 2'h0;
          wait_d = SLAVE_WAIT_CYC;
          st_d = PBTH_DATA;
        end
      end
      PBTH_DATA: begin
        doe_d = is_out(req_q.dir);
        if (wait_q != 2'h0) begin
          wait_d = wait_q - 2'h1;
        end else begin
          ta_d = 1'b1;
          beat_ev_d = 1'b1;
          wait_d = SLAVE_WAIT_CYC;
          if (!is_out(req_q.dir)) begin
            rdata_d = din;
            lv_d = 8'hff;
          end
          if (!req_q.burst || beat_q == BURST_BEATS_M1) begin
            // Data keeps standing alongside the last beat acknowledge
            done_d = 1'b1;
            st_d = PBTH_IDLE;
          end else begin
            beat_d = beat_q + 2'h1;
          end
        end
      end
      PBTH_MADDR: begin
        bg_d = 1'b0;
        aoe_d = ~address_acknowledge_in;
        if (address_acknowledge_in) begin
          st_d = PBTH_MRTRY;
        end
      end
      PBTH_MRTRY: begin
        // Address released; sample retry now
        if (rtry_in) begin
          rtd_d = 1'b1;
          st_d = PBTH_IDLE;
        end else begin
          beat_d = 2'h0;
          doe_d = 1'b1;
          st_d = PBTH_MDATA;
        end
      end
      PBTH_MDATA: begin
        doe_d = 1'b1;
        if (tea_in) begin
          err_d = 1'b1;
          doe_d = 1'b0;
          st_d = PBTH_IDLE;
        end else if (ta_in) begin
          beat_ev_d = 1'b1;
          if (!req_q.burst || beat_q == BURST_BEATS_M1) begin
            done_d = 1'b1;
            doe_d = 1'b0;
            st_d = PBTH_IDLE;
          end else begin
            beat_d = beat_q + 2'h1;
          end
        end
      end
      PBTH_ERR: begin
        // Error ended tenure; no beat acknowledge given
        st_d = PBTH_IDLE;
      end
    endcase
  end

  // Register stage
  always_ff @(posedge I_CLOCK or negedge I_RST_N) begin
    if (!I_RST_N) begin
      st_q <= PBTH_IDLE;
      req_q <= '0;
      beat_q <= 2'h0;
      wait_q <= 2'h0;
      address_acknowledge_q <= 1'b0;
      rtry_q <= 1'b0;
      ts_q <= 1'b0;
      aoe_q <= 1'b0;
      bg_q <= 1'b0;
      dbg_q <= 1'b0;
      ta_q <= 1'b0;
      tea_q <= 1'b0;
      doe_q <= 1'b0;
      beat_ev_q <= 1'b0;
      done_q <= 1'b0;
      rtd_q <= 1'b0;
      err_q <= 1'b0;
      coh_q <= 1'b0;
      rdata_q <= '0;
      lv_q <= 8'h00;
    end else if (I_CE) begin
      st_q <= st_d;
      req_q <= req_d;
      beat_q <= beat_d;
      wait_q <= wait_d;
      address_acknowledge_q <= address_acknowledge_d;
      rtry_q <= rtry_d;
      ts_q <= ts_d;
      aoe_q <= aoe_d;
      bg_q <= bg_d;
      dbg_q <= dbg_d;
      ta_q <= ta_d;
      tea_q <= tea_d;
      doe_q <= doe_d;
      beat_ev_q <= beat_ev_d;
      done_q <= done_d;
      rtd_q <= rtd_d;
      err_q <= err_d;
      coh_q <= coh_d;
      rdata_q <= rdata_d;
      lv_q <= lv_d;
    end
  end

  // Registered data and attributes out
  logic [DATA_W-1:0] wd_q;  // Outbound data
  pbth_attr_t        at_q;  // Outbound attributes, low true
  logic              atoe_q; // Attribute drive

  // Lane ordering of outbound data
  logic [DATA_W-1:0] wd_d;
  always_comb begin
    wd_d = '0;
    for (int k = 0; k < LANES; k++) begin
      wd_d[DATA_W-1-k*LANE_W -: LANE_W] = lane_of(I_WDATA, k);
    end
  end

  // Outbound data and attribute register
  always_ff @(posedge I_CLOCK or negedge I_RST_N) begin
    if (!I_RST_N) begin
      wd_q <= '0;
      at_q <= 3'h7;
      atoe_q <= 1'b0;
    end else if (I_CE) begin
      wd_q <= wd_d;
      at_q <= ~req_d.attr;
      atoe_q <= ts_d;
    end
  end

  // Pin drivers, all from flip-flops, active low where named
  assign O_ADDRESS_ACKNOWLEDGE_N = ~address_acknowledge_q;
  assign O_ADDRESS_RETRY_N       = ~rtry_q;
  assign O_ADDRESS_RETRY_OE      = rtry_q;
  assign O_TRANSFER_START_N      = ~ts_q;
  assign O_ADDR_OE               = aoe_q;
  assign O_BUS_GRANT_ZERO_N      = ~bg_q;
  assign O_DATA_GRANT_ZERO_N     = ~dbg_q;
  assign O_BEAT_ACKNOWLEDGE_N    = ~ta_q;
  assign O_TRANSFER_ERROR_ACK_N  = ~tea_q;
  assign O_HIGH_WORD_LANES       = wd_q[DATA_W-1 -: HALF_W];
  assign O_LOW_WORD_LANES        = wd_q[HALF_W-1:0];
  assign O_DATA_OE               = doe_q;
  assign O_ATTR_N                = at_q;
  assign O_ATTR_OE               = atoe_q;
  assign O_RDATA                 = rdata_q;
  assign O_LANE_VALID            = lv_q;
  assign O_BEAT                  = beat_ev_q;
  assign O_DONE                  = done_q;
  assign O_RETRIED               = rtd_q;
  assign O_ERROR                 = err_q;
  assign O_COHERENT              = coh_q;

endmodule : pbth_tenure
`default_nettype wire
